// ---- hw/interp_cfg_pkg.sv ----
/*
   Constants shared by both ends of the interpolator configuration link:
   link addresses, field positions, reset values, write masks, host command
   layout and the recommended-settings function.
   Assumes every file that uses it imports it whole.
*/
package interp_cfg_pkg;

   // ==================================================================
   // Link addresses (byte addresses, writes are one byte each)
   localparam logic [7:0] ADDR_CFG_ONE    = 8'h0C;
   localparam logic [7:0] ADDR_CFG_TWO    = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h34;
   localparam logic [7:0] ADDR_FAULT_STAT = 8'h38;
   localparam logic [7:0] ADDR_TRIG_HOLD  = 8'h3C;

   // ==================================================================
   // Word one field positions
   localparam int POS_NOISE_FILTER   = 30;
   localparam int POS_OFFSET_SAVE    = 29;
   localparam int POS_AMP_SAVE       = 28;
   localparam int POS_SEQUENCE_SAVE  = 27;
   localparam int POS_SPEED_SAVE     = 26;
   localparam int POS_CONV_SAVE      = 25;
   localparam int POS_VECTOR_SAVE    = 24;
   localparam int POS_OFFSET_DET     = 21;
   localparam int POS_AMP_DET        = 20;
   localparam int POS_SQUARE_CHECK   = 19;
   localparam int POS_SPEED_DET      = 18;
   localparam int POS_CONV_DET       = 17;
   localparam int POS_VECTOR_DET     = 16;
   localparam int POS_AMP_SEL_HI     = 15;
   localparam int POS_AMP_SEL_LO     = 14;
   localparam int POS_TRIG_EDGE      = 13;
   localparam int POS_HYSTERESIS     = 12;
   localparam int POS_RESERVED       = 11;
   localparam int POS_EDGE_INT_MSB   = 10;
   localparam int POS_REF_DISABLE    = 5;
   localparam int POS_ZERO_WIDTH     = 4;

   // ==================================================================
   // Reset values, pin-loaded fields and writable bits
   localparam logic [31:0] CFG_ONE_RESET   = 32'h007F0000;
   localparam logic [31:0] CFG_ONE_PINMASK = 32'h0000DBDF;
   localparam logic [31:0] CFG_ONE_WMASK   = 32'h7FFFFFFF;
   localparam logic [31:0] CFG_TWO_RESET   = 32'h00000000;
   localparam logic [31:0] CFG_TWO_WMASK   = 32'h7F1FFFFF;
   localparam logic [1:0]  AMP_SMALLEST    = 2'h3;

   // Recommended detect/save sets per operating mode
   localparam logic [31:0] COUNTER_SET     = 32'h37370000;
   localparam logic [31:0] COUNTER_CLR     = 32'h00080000;
   localparam logic [31:0] SQUARE_SET      = 32'h003F0000;
   localparam logic [31:0] SQUARE_CLR      = 32'h3F000000;

   // ==================================================================
   // Device status bits
   localparam int EVT_CONV    = 0;
   localparam int EVT_VECTOR  = 1;
   localparam int EVT_TRIGGER = 2;
   localparam int FLT_SINE    = 0;
   localparam int FLT_COSINE  = 1;
   localparam int FLT_VECTOR  = 2;

   // ==================================================================
   // Host software registers
   localparam logic [7:0] HREG_WORD_ONE = 8'h00;
   localparam logic [7:0] HREG_WORD_TWO = 8'h04;
   localparam logic [7:0] HREG_COMMAND  = 8'h08;
   localparam logic [7:0] HREG_STATUS   = 8'h0C;
   localparam logic [7:0] HREG_READBACK = 8'h10;
   localparam logic [7:0] HREG_EVENT    = 8'h14;
   localparam logic [7:0] HREG_MASK     = 8'h18;
   localparam int CMD_WRITE_ONE = 0;
   localparam int CMD_WRITE_TWO = 1;
   localparam int CMD_READ_ONE  = 2;
   localparam int CMD_READ_TWO  = 3;
   localparam int CMD_RECOMMEND = 4;
   localparam logic [1:0] LAST_BYTE = 2'h3;

   // Word one as the host may legally send it
   function automatic logic [31:0] legal_word_one(input logic [31:0] w, input logic rec);
      logic [31:0] r;
      r = w;
      if (rec && !w[POS_SQUARE_CHECK])
         r = (r | COUNTER_SET) & ~COUNTER_CLR;
      if (rec && w[POS_SQUARE_CHECK])
         r = (r | SQUARE_SET) & ~SQUARE_CLR;
      r[POS_RESERVED] = 1'b0;
      if (r[POS_AMP_SEL_HI:POS_AMP_SEL_LO] == AMP_SMALLEST)
         r[POS_NOISE_FILTER] = 1'b1;
      return r;
   endfunction : legal_word_one

endpackage : interp_cfg_pkg

// ---- hw/interp_cfg_if.sv ----
/*
   Configuration link between host controller and interpolator register bank.
   Assumes both ends share one clock; read data answer one cycle after the strobe.
*/
`timescale 1ns/1ps
interface interp_cfg_if;
   logic        wr_stb;
   logic        rd_stb;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic [31:0] rdata;

   modport device (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
   modport host   (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
endinterface : interp_cfg_if

// ---- hw/cfg_word_reg.sv ----
/*
   One 32-bit configuration word written byte by byte, with pin-loaded fields.
   Assumes pin_load has priority over a byte write on the pin fields only.
*/
`timescale 1ns/1ps
module cfg_word_reg
#(
   parameter logic [31:0] RESET_VAL  = 32'h00000000,
   parameter logic [31:0] WRITE_MASK = 32'hFFFFFFFF,
   parameter logic [31:0] PIN_MASK   = 32'h00000000
)
(
   input  wire logic        CLOCK,
   input  wire logic        ARST_N,
   input  wire logic        CE,
   input  wire logic        pin_load,
   input  wire logic [31:0] pin_value,
   input  wire logic        byte_we,
   input  wire logic [1:0]  byte_sel,
   input  wire logic [7:0]  byte_data,
   output logic      [31:0] word
);
   // ==================================================================
   // Byte lane merge
   logic [31:0] word_reg;
   logic [31:0] word_next;
   wire  [31:0] lane   = 32'h000000FF << {byte_sel, 3'h0};
   wire  [31:0] wmask  = lane & WRITE_MASK;
   wire  [31:0] merged = (word_reg & ~wmask) | ({4{byte_data}} & wmask);
   wire  [31:0] written = byte_we ? merged : word_reg;
   wire  [31:0] loaded  = (written & ~PIN_MASK) | (pin_value & PIN_MASK);

   assign word_next = pin_load ? loaded : written;
   assign word      = word_reg;

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
         word_reg <= RESET_VAL;
      else if (CE)
         word_reg <= word_next;
   end
endmodule : cfg_word_reg

// ---- hw/interp_cfg_regs.sv ----
/*
   Interpolator register bank: configuration words one and two, fault status,
   trigger holding register and interrupt status/mask, reached over the link.
   Assumes configuration pins, fault inputs and trigger are synchronous to CLOCK.
*/
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module interp_cfg_regs
   import interp_cfg_pkg::*;
#(
   parameter int MEAS_WIDTH = 32
)
(
   input  wire logic                  CLOCK,
   input  wire logic                  ARST_N,
   input  wire logic                  CE,
   interp_cfg_if.device               LINK,
   input  wire logic [1:0]            AMPLITUDE_CFG_PIN,
   input  wire logic                  FILTER_CFG_PIN,
   input  wire logic [1:0]            EDGE_INTERVAL_CFG_PIN,
   input  wire logic [1:0]            MODE_PIN,
   input  wire logic                  ZERO_WIDTH_RATE_PIN,
   input  wire logic [2:0]            RATE_PINS,
   input  wire logic                  SINE_CONV_FAULT,
   input  wire logic                  COSINE_CONV_FAULT,
   input  wire logic                  VECTOR_LOW_FAULT,
   input  wire logic                  TRIGGER_INPUT,
   input  wire logic [MEAS_WIDTH-1:0] MEAS_VALUE,
   output logic      [31:0]           CONFIG_WORD_ONE,
   output logic      [31:0]           CONFIG_WORD_TWO,
   output logic                       SQUARE_WAVE_MODE,
   output logic      [MEAS_WIDTH-1:0] TRIG_HOLD,
   output logic                       IRQ
);
   import interp_cfg_pkg::*;

   // ==================================================================
   // Pin sampling after reset
   logic        load_pending_reg;
   logic [31:0] cfg_one;
   logic [31:0] cfg_two;
   wire  [31:0] pin_value = {16'h0000, AMPLITUDE_CFG_PIN, 1'b0,
                             FILTER_CFG_PIN, FILTER_CFG_PIN, 1'b0,
                             EDGE_INTERVAL_CFG_PIN, MODE_PIN, 1'b0,
                             ZERO_WIDTH_RATE_PIN, ZERO_WIDTH_RATE_PIN,
                             RATE_PINS};

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
         load_pending_reg <= 1'b1;
      else if (CE)
         load_pending_reg <= 1'b0;
   end

   // ==================================================================
   // Address decode
   wire [7:0] addr      = LINK.addr;
   wire       hit_one   = addr[7:2] == ADDR_CFG_ONE[7:2];
   wire       hit_two   = addr[7:2] == ADDR_CFG_TWO[7:2];
   wire       wr_one    = LINK.wr_stb && hit_one;
   wire       wr_two    = LINK.wr_stb && hit_two;
   wire       wr_istat  = LINK.wr_stb && addr == ADDR_IRQ_STATUS;
   wire       wr_imask  = LINK.wr_stb && addr == ADDR_IRQ_MASK;
   wire       wr_fstat  = LINK.wr_stb && addr == ADDR_FAULT_STAT;

   // ==================================================================
   // Configuration words
   cfg_word_reg #(
      .RESET_VAL  (CFG_ONE_RESET),
      .WRITE_MASK (CFG_ONE_WMASK),
      .PIN_MASK   (CFG_ONE_PINMASK)
   ) u_word_one (
      .CLOCK     (CLOCK),
      .ARST_N    (ARST_N),
      .CE        (CE),
      .pin_load  (load_pending_reg),
      .pin_value (pin_value),
      .byte_we   (wr_one),
      .byte_sel  (addr[1:0]),
      .byte_data (LINK.wdata),
      .word      (cfg_one)
   );

   cfg_word_reg #(
      .RESET_VAL  (CFG_TWO_RESET),
      .WRITE_MASK (CFG_TWO_WMASK),
      .PIN_MASK   (32'h00000000)
   ) u_word_two (
      .CLOCK     (CLOCK),
      .ARST_N    (ARST_N),
      .CE        (CE),
      .pin_load  (1'b0),
      .pin_value (32'h00000000),
      .byte_we   (wr_two),
      .byte_sel  (addr[1:0]),
      .byte_data (LINK.wdata),
      .word      (cfg_two)
   );

   assign CONFIG_WORD_ONE  = cfg_one;
   assign CONFIG_WORD_TWO  = cfg_two;
   assign SQUARE_WAVE_MODE = cfg_one[POS_SQUARE_CHECK];

   // ==================================================================
   // Fault detection and saving
   logic [2:0] fault_reg;
   logic [2:0] fault_next;
   wire  [2:0] fault_det  = {VECTOR_LOW_FAULT  & cfg_one[POS_VECTOR_DET],
                             COSINE_CONV_FAULT & cfg_one[POS_CONV_DET],
                             SINE_CONV_FAULT   & cfg_one[POS_CONV_DET]};
   wire  [2:0] fault_save = {cfg_one[POS_VECTOR_SAVE], {2{cfg_one[POS_CONV_SAVE]}}};
   wire  [2:0] fault_clr  = wr_fstat ? LINK.wdata[2:0] : 3'h0;
   wire  [2:0] fault_kept = fault_reg & ~fault_clr & fault_save;

   assign fault_next = fault_det | fault_kept;

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
         fault_reg <= 3'h0;
      else if (CE)
         fault_reg <= fault_next;
   end

   // ==================================================================
   // Trigger capture
   logic                  trig_prev_reg;
   logic [MEAS_WIDTH-1:0] trig_hold_reg;
   wire  trig_rise = TRIGGER_INPUT & ~trig_prev_reg;
   wire  trig_fall = ~TRIGGER_INPUT & trig_prev_reg;
   wire  trig_hit  = cfg_one[POS_TRIG_EDGE] ? trig_rise : trig_fall;

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         trig_prev_reg <= 1'b0;
         trig_hold_reg <= '0;
      end
      else if (CE)
      begin
         trig_prev_reg <= TRIGGER_INPUT;
         if (trig_hit)
            trig_hold_reg <= MEAS_VALUE;
      end
   end

   assign TRIG_HOLD = trig_hold_reg;

   // ==================================================================
   // Interrupt status and mask
   logic [2:0] irq_stat_reg;
   logic [2:0] irq_mask_reg;
   logic       irq_reg;
   wire  [2:0] irq_events = {trig_hit, |fault_det[2], |fault_det[1:0]};
   wire  [2:0] irq_clr    = wr_istat ? LINK.wdata[2:0] : 3'h0;
   wire  [2:0] irq_next   = irq_events | (irq_stat_reg & ~irq_clr);

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         irq_stat_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
         irq_reg      <= 1'b0;
      end
      else if (CE)
      begin
         irq_stat_reg <= irq_next;
         if (wr_imask)
            irq_mask_reg <= LINK.wdata[2:0];
         irq_reg <= |(irq_next & (wr_imask ? LINK.wdata[2:0] : irq_mask_reg));
      end
   end

   assign IRQ = irq_reg;

   // ==================================================================
   // Read data, one cycle after the strobe
   logic [31:0] rdata_reg;
   wire  [31:0] trig_word = 32'(trig_hold_reg);
   wire  [31:0] rd_value  = hit_one ? cfg_one :
                            hit_two ? cfg_two :
                            addr == ADDR_IRQ_STATUS ? {29'h0, irq_stat_reg} :
                            addr == ADDR_IRQ_MASK   ? {29'h0, irq_mask_reg} :
                            addr == ADDR_FAULT_STAT ? {29'h0, fault_reg} :
                            addr == ADDR_TRIG_HOLD  ? trig_word : 32'h00000000;

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
         rdata_reg <= 32'h00000000;
      else if (CE)
         rdata_reg <= LINK.rd_stb ? rd_value : 32'h00000000;
   end

   assign LINK.rdata = rdata_reg;
endmodule : interp_cfg_regs

// ---- hw/interp_cfg_host.sv ----
/*
   Host controller for the interpolator configuration link: software fills
   shadow words and issues write or read commands, the controller sends
   bytes or fetches words over the link.
   Assumes the device answers a read one cycle after the strobe.
*/
`timescale 1ns/1ps
module interp_cfg_host
   import interp_cfg_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        ARST_N,
   input  wire logic        CE,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   output logic             IRQ,
   interp_cfg_if.host       LINK
);
   import interp_cfg_pkg::*;

   typedef enum logic [1:0] {IDLE, WRITE, READ, WAIT} state_t;

   // ==================================================================
   // Software registers
   state_t      state_reg;
   logic [31:0] word_one_reg;
   logic [31:0] word_two_reg;
   logic [31:0] readback_reg;
   logic [31:0] tx_word_reg;
   logic [1:0]  byte_reg;
   logic        done_reg;
   logic        mask_reg;
   logic        irq_reg;
   logic [31:0] rdata_reg;
   logic        wr_stb_reg;
   logic        rd_stb_reg;
   logic [7:0]  addr_reg;
   logic [7:0]  wdata_reg;

   wire        idle     = state_reg == IDLE;
   wire        cmd_wr   = WR && ADDR == HREG_COMMAND && idle;
   wire        go_one   = cmd_wr && WDATA[CMD_WRITE_ONE];
   wire        go_two   = cmd_wr && !WDATA[CMD_WRITE_ONE] && WDATA[CMD_WRITE_TWO];
   wire        go_rd    = cmd_wr && !WDATA[CMD_WRITE_ONE] && !WDATA[CMD_WRITE_TWO]
                          && (WDATA[CMD_READ_ONE] || WDATA[CMD_READ_TWO]);
   wire [7:0]  rd_addr  = WDATA[CMD_READ_ONE] ? ADDR_CFG_ONE : ADDR_CFG_TWO;
   wire [31:0] tx_one   = legal_word_one(word_one_reg, WDATA[CMD_RECOMMEND]);
   wire [31:0] tx_two   = word_two_reg & CFG_TWO_WMASK;
   wire [31:0] tx_word  = go_one ? tx_one : tx_two;
   wire [1:0]  next_b   = byte_reg + 2'h1;
   wire [31:0] tx_shift = tx_word_reg >> {next_b, 3'h0};
   wire        finish   = (state_reg == WRITE && byte_reg == LAST_BYTE) || state_reg == WAIT;
   wire        done_clr = WR && ADDR == HREG_EVENT && WDATA[0];
   wire        done_nx  = finish | (done_reg & ~done_clr);
   wire        mask_nx  = (WR && ADDR == HREG_MASK) ? WDATA[0] : mask_reg;
   wire [31:0] rd_value = ADDR == HREG_WORD_ONE ? word_one_reg :
                          ADDR == HREG_WORD_TWO ? word_two_reg :
                          ADDR == HREG_STATUS   ? {31'h0, !idle} :
                          ADDR == HREG_READBACK ? readback_reg :
                          ADDR == HREG_EVENT    ? {31'h0, done_reg} :
                          ADDR == HREG_MASK     ? {31'h0, mask_reg} : 32'h00000000;

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         word_one_reg <= CFG_ONE_RESET;
         word_two_reg <= CFG_TWO_RESET;
         done_reg     <= 1'b0;
         mask_reg     <= 1'b0;
         irq_reg      <= 1'b0;
         rdata_reg    <= 32'h00000000;
      end
      else if (CE)
      begin
         if (WR && ADDR == HREG_WORD_ONE)
            word_one_reg <= WDATA;
         if (WR && ADDR == HREG_WORD_TWO)
            word_two_reg <= WDATA;
         done_reg  <= done_nx;
         mask_reg  <= mask_nx;
         irq_reg   <= done_nx & mask_nx;
         rdata_reg <= RD ? rd_value : 32'h00000000;
      end
   end

   // ==================================================================
   // Link sequencer
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         state_reg    <= IDLE;
         tx_word_reg  <= 32'h00000000;
         byte_reg     <= 2'h0;
         readback_reg <= 32'h00000000;
         wr_stb_reg   <= 1'b0;
         rd_stb_reg   <= 1'b0;
         addr_reg     <= 8'h00;
         wdata_reg    <= 8'h00;
      end
      else if (CE)
      begin
         case (state_reg)
            IDLE:
            begin
               if (go_one || go_two)
               begin
                  state_reg   <= WRITE;
                  tx_word_reg <= tx_word;
                  byte_reg    <= 2'h0;
                  wr_stb_reg  <= 1'b1;
                  addr_reg    <= go_one ? ADDR_CFG_ONE : ADDR_CFG_TWO;
                  wdata_reg   <= tx_word[7:0];
               end
               else if (go_rd)
               begin
                  state_reg  <= READ;
                  rd_stb_reg <= 1'b1;
                  addr_reg   <= rd_addr;
               end
            end
            WRITE:
            begin
               if (byte_reg == LAST_BYTE)
               begin
                  state_reg  <= IDLE;
                  wr_stb_reg <= 1'b0;
               end
               else
               begin
                  byte_reg  <= next_b;
                  addr_reg  <= addr_reg + 8'h01;
                  wdata_reg <= tx_shift[7:0];
               end
            end
            READ:
            begin
               rd_stb_reg <= 1'b0;
               state_reg  <= WAIT;
            end
            WAIT:
            begin
               readback_reg <= LINK.rdata;
               state_reg    <= IDLE;
            end
            default:
               state_reg <= IDLE;
         endcase
      end
   end

   assign LINK.wr_stb = wr_stb_reg;
   assign LINK.rd_stb = rd_stb_reg;
   assign LINK.addr   = addr_reg;
   assign LINK.wdata  = wdata_reg;
   assign RDATA       = rdata_reg;
   assign IRQ         = irq_reg;
endmodule : interp_cfg_host

// ---- verification/interp_cfg_asserts.sv ----
/*
   Link checker for the interpolator configuration link.
   Assumes one clock and takes the interface signals as plain inputs.
*/
`timescale 1ns/1ps
module interp_cfg_asserts
   import interp_cfg_pkg::*;
(
   input wire logic        CLOCK,
   input wire logic        ARST_N,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire logic [7:0]  addr,
   input wire logic [7:0]  wdata,
   input wire logic [31:0] rdata
);
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!ARST_N);
   // =====
   // Link protocol
   a_no_both_strobes:
   assert property (!(wr_stb && rd_stb)) else $error("write and read strobe together");
   a_byte_order_up:
   assert property (wr_stb && addr[1:0] != LAST_BYTE |=> wr_stb && addr == $past(addr) + 8'h01)
      else $error("byte addresses not consecutive");
   a_word_write_end:
   assert property (wr_stb && addr[1:0] == LAST_BYTE |=> !wr_stb) else $error("write runs past byte 3");
   a_read_one_pulse:
   assert property (rd_stb |=> !rd_stb && !wr_stb) else $error("read strobe too long");
   a_idle_rdata_zero:
   assert property (!rd_stb |=> rdata == 32'h0) else $error("read data without read");
   a_word_two_gaps:
   assert property (rd_stb && addr == ADDR_CFG_TWO |=> !rdata[31] && rdata[23:21] == 3'h0)
      else $error("unused bits of word two set");
   a_word_one_top:
   assert property (rd_stb && addr == ADDR_CFG_ONE |=> !rdata[31]) else $error("word one bit 31 set");
   a_reserved_kept_zero:
   assert property (wr_stb && addr == ADDR_CFG_ONE + 8'h01 |-> !wdata[3])
      else $error("reserved bit sent as one");
   a_filter_with_small:
   assert property (wr_stb && addr == ADDR_CFG_ONE + 8'h01 && wdata[7:6] == AMP_SMALLEST
      |-> ##2 wdata[6]) else $error("noise filter off at smallest amplitude");
   a_two_unused_sent:
   assert property (wr_stb && addr == ADDR_CFG_TWO + 8'h02 |-> wdata[7:5] == 3'h0 ##1 !wdata[7])
      else $error("unused bits of word two sent");
   // =====
   // Coverage
   c_word_two_write: cover property (wr_stb && addr == ADDR_CFG_TWO + 8'h03);
   c_read_answer: cover property (rd_stb ##1 rdata != 32'h0);
   c_small_amp: cover property (wr_stb && addr == ADDR_CFG_ONE + 8'h01 && wdata[7:6] == AMP_SMALLEST);
endmodule : interp_cfg_asserts

// ---- verification/tb_interp_config_registers.sv ----
/*
   Testbench: host controller and register bank joined by the link.
   Assumes the package, interface and both design ends are compiled first.
*/
`timescale 1ns/1ps
module tb_interp_config_registers;
   import interp_cfg_pkg::*;
   logic        clk, arst_n, ce, wr, rd, trig, irq, dirq, sqm;
   logic [7:0]  adr;
   logic [2:0]  flt;
   logic [10:0] cfgp;
   logic [31:0] wd, rdat, w1, w2, q, meas, hold;
   int          miscompares, n_compared, cyc;
   interp_cfg_if interp_cfg_if_i ();
   interp_cfg_regs interp_cfg_regs_i (.CLOCK(clk), .ARST_N(arst_n), .CE(ce),
      .LINK(interp_cfg_if_i), .AMPLITUDE_CFG_PIN(cfgp[10:9]), .FILTER_CFG_PIN(cfgp[8]),
      .EDGE_INTERVAL_CFG_PIN(cfgp[7:6]), .MODE_PIN(cfgp[5:4]), .ZERO_WIDTH_RATE_PIN(cfgp[3]),
      .RATE_PINS(cfgp[2:0]), .SINE_CONV_FAULT(flt[0]), .COSINE_CONV_FAULT(flt[1]),
      .VECTOR_LOW_FAULT(flt[2]), .TRIGGER_INPUT(trig), .MEAS_VALUE(meas),
      .CONFIG_WORD_ONE(w1), .CONFIG_WORD_TWO(w2), .SQUARE_WAVE_MODE(sqm),
      .TRIG_HOLD(hold), .IRQ(dirq));
   interp_cfg_host interp_cfg_host_i (.CLOCK(clk), .ARST_N(arst_n), .CE(ce), .ADDR(adr),
      .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdat), .IRQ(irq), .LINK(interp_cfg_if_i));
   interp_cfg_asserts interp_cfg_asserts_i (.CLOCK(clk), .ARST_N(arst_n),
      .wr_stb(interp_cfg_if_i.wr_stb), .rd_stb(interp_cfg_if_i.rd_stb),
      .addr(interp_cfg_if_i.addr), .wdata(interp_cfg_if_i.wdata), .rdata(interp_cfg_if_i.rdata));
   // =====
   // Tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdat, e);
      @(posedge clk);
   endtask : rc
   task automatic cmd(input logic [31:0] c);
      wr_reg(HREG_COMMAND, c);
      for (int i = 0; i < 20; i++)
      begin
         adr <= HREG_STATUS;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 q = rdat;
         @(posedge clk);
         if (q[0] === 1'b0)
            break;
      end
      chk(q, 32'h0);
   endtask : cmd
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim
   // =====
   // Clock and timeout
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         miscompares++;
         end_sim();
      end
   end
   // =====
   // Tests
   initial
   begin
      {arst_n, wr, rd, trig, flt, adr, wd, meas} = '0;
      cfgp = 11'h57D;
      ce = 1'b1;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk(w1, 32'h007F99DD);
      chk(w2, 32'h0);
      meas <= 32'h00001111;
      trig <= 1'b1;
      @(posedge clk);
      meas <= 32'h00002222;
      trig <= 1'b0;
      repeat (3) @(posedge clk);
      chk(hold, 32'h00002222);
      $display("reset test done");
      @(posedge clk);
      wr_reg(HREG_WORD_ONE, 32'h0000F8A5);
      cmd(32'h1);
      chk(w1, 32'h4000F0A5);
      cmd(32'h4);
      rc(HREG_READBACK, 32'h4000F0A5);
      rc(HREG_WORD_ONE, 32'h0000F8A5);
      $display("word one test done");
      cmd(32'h11);
      chk(w1, 32'h7737F0A5);
      chk({31'h0, sqm}, 32'h0);
      wr_reg(HREG_WORD_ONE, 32'h0008F8A5);
      cmd(32'h11);
      chk(w1, 32'h403FF0A5);
      chk({31'h0, sqm}, 32'h1);
      $display("mode test done");
      wr_reg(HREG_WORD_TWO, 32'hFFFFFFFF);
      cmd(32'h2);
      chk(w2, 32'h7F1FFFFF);
      cmd(32'h8);
      rc(HREG_READBACK, 32'h7F1FFFFF);
      $display("word two test done");
      meas <= 32'h12345678;
      trig <= 1'b1;
      flt <= 3'h7;
      repeat (3) @(posedge clk);
      chk(hold, 32'h12345678);
      chk({29'h0, interp_cfg_regs_i.fault_reg}, 32'h7);
      flt <= 3'h0;
      meas <= 32'h0000ABCD;
      trig <= 1'b0;
      repeat (3) @(posedge clk);
      chk(hold, 32'h12345678);
      chk({31'h0, dirq}, 32'h0);
      chk({29'h0, interp_cfg_regs_i.fault_reg}, 32'h0);
      $display("trigger test done");
      rc(HREG_EVENT, 32'h1);
      wr_reg(HREG_MASK, 32'h1);
      #1 chk({31'h0, irq}, 32'h1);
      @(posedge clk);
      wr_reg(HREG_EVENT, 32'h1);
      #1 chk({31'h0, irq}, 32'h0);
      $display("interrupt test done");
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(HREG_MASK, 32'h0);
      ce <= 1'b1;
      rc(HREG_MASK, 32'h1);
      $display("clock enable test done");
      end_sim();
   end
endmodule : tb_interp_config_registers
